// ===== sim/fp_panel_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fp_panel_chk
	import fp_scan_pkg::*;
#(
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYC
)(
	// Clock and reset
	input wire logic             i_sys_clk,
	input wire logic             i_srst,
	// Link signals
	input wire logic             scan_update_select,
	input wire logic             key_read_scan_select,
	input wire logic             key_interrupt,
	input wire logic [COLS-1:0]  column_data_buffer,
	// Panel signals
	input wire logic [COLS-1:0]  i_key_columns,
	input wire logic             i_gate_active,
	input wire logic [DEC_W-1:0] o_digit_drive,
	input wire logic [SEG_W-1:0] o_segment_drive,
	input wire logic             o_gate_lamp,
	input wire logic [ROWS-1:0]  o_key_rows_n
);
	// ******
	// Helpers
	// ******
	localparam int DEB_LO  = DEBOUNCE_LEN;
	localparam int DEB_HI  = DEBOUNCE_LEN + 3;
	localparam int DEB_DUE = DEBOUNCE_LEN + 5;
	logic [7:0]      det_cnt;
	logic [ROWS-1:0] rows_q;
	wire             det_now = (i_key_columns != COL_IDLE);
	wire             scan_key = det_now && !key_read_scan_select;

	// Unbroken detect run; it saturates so a long press never wraps.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst || !det_now)
			det_cnt <= 8'h00;
		else if (det_cnt != 8'hff)
			det_cnt <= det_cnt + 8'h01;
		rows_q <= o_key_rows_n;
	end

	// ******
	// Properties
	// ******
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	digit_one_hot_a:
		assert property ($onehot0(o_digit_drive) && !o_digit_drive[15])
		else $error("Digit drive not one-hot.");
	blank_dark_a:
		assert property (scan_update_select [*3] ##0 o_digit_drive == '0
			|-> o_segment_drive == '0) else $error("Segments lit unselected.");
	update_dark_a:
		assert property (!scan_update_select [*3] |-> o_digit_drive == '0)
		else $error("Digit driven in update mode.");
	gate_copy_a:
		assert property (!$past(i_srst) |-> o_gate_lamp == $past(i_gate_active))
		else $error("Gate lamp off the gate.");
	row_one_low_a:
		assert property ($countones(o_key_rows_n) == ROWS - 1)
		else $error("Not one row low.");
	row_rotate_a:
		assert property ($changed(o_key_rows_n) && !$past(i_srst)
			&& !($past(key_read_scan_select)
			&& !$past(key_read_scan_select, 2))
			|-> o_key_rows_n == {rows_q[ROWS-2:0], rows_q[ROWS-1]})
		else $error("Row pattern did not rotate.");
	row_restart_a:
		assert property ($past(key_read_scan_select)
			&& !$past(key_read_scan_select, 2) |-> o_key_rows_n == ROW_FIRST)
		else $error("Read did not start at the first row.");
	scan_halt_a:
		assert property (scan_key [*2] |=> $stable(o_key_rows_n))
		else $error("Row scan ran with a key down.");
	irq_debounce_a:
		assert property (!key_read_scan_select && $rose(key_interrupt)
			|-> int'(det_cnt) inside {[DEB_LO:DEB_HI]})
		else $error("Interrupt rose off the debounce count.");
	irq_due_a:
		assert property (scan_key && int'(det_cnt) == DEB_DUE |-> key_interrupt)
		else $error("Interrupt late.");
	irq_drop_a:
		assert property ((!det_now && !key_read_scan_select) [*4]
			|-> !key_interrupt) else $error("Interrupt with no key.");
	buf_idle_a:
		assert property (!key_read_scan_select [*2]
			|-> column_data_buffer == COL_IDLE) else $error("Buffer open.");
	buf_read_a:
		assert property (key_read_scan_select [*2]
			|-> column_data_buffer == $past(i_key_columns))
		else $error("Buffer lost the columns.");
	cover property ($rose(key_interrupt));
	cover property ($fell(scan_update_select));
	cover property ($rose(key_read_scan_select));
endmodule // fp_panel_chk
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fp_scan_pkg::*;
	localparam int DEB  = 3;
	localparam int STEP = 4;
	// ******
	// Signals and instances
	// ******
	logic                 i_sys_clk = 1'b0;
	logic                 i_srst = 1'b1;
	logic                 load_start = 1'b0;
	logic                 read_start = 1'b0;
	logic                 i_gate_active = 1'b0;
	logic                 key_on = 1'b0;
	logic                 disp_on = 1'b0;
	logic [1:0]           key_r = 2'h0;
	logic [2:0]           key_c = 3'h0;
	logic [DIV_W-1:0]     intensity = 16'h0000;
	logic [SEG_W-1:0]     load_data [NUM_SLOTS];
	logic [DEC_W-1:0]     o_digit_drive;
	logic [DEC_W-1:0]     seen_slots = 16'h0000;
	logic [SEG_W-1:0]     o_segment_drive;
	logic [ROWS-1:0]      o_key_rows_n;
	logic [COLS-1:0]      i_key_columns;
	logic                 o_gate_lamp;
	logic                 busy;
	logic                 key_valid;
	logic [ROWS*COLS-1:0] key_map;
	logic [ROWS*COLS-1:0] key_q [$];
	int                   lit = 0;
	int                   err_count = 0;
	int                   n_checks = 0;
	fp_link_if lnk ();

	// Matrix wiring: a held key grounds its column while its row is low.
	assign i_key_columns = (key_on && !o_key_rows_n[key_r]) ?
		~(7'h01 << key_c) : COL_IDLE;
	always #5 i_sys_clk = ~i_sys_clk;

	fp_panel_device #(.SCAN_DIVIDE(STEP), .KEY_DIVIDE(STEP),
		.DEBOUNCE_LEN(DEB)) fp_panel_device_inst (.i_sys_clk(i_sys_clk),
		.i_srst(i_srst), .link(lnk), .i_intensity_adjust(intensity),
		.i_gate_active(i_gate_active), .i_key_columns(i_key_columns),
		.o_digit_drive(o_digit_drive), .o_segment_drive(o_segment_drive),
		.o_gate_lamp(o_gate_lamp), .o_key_rows_n(o_key_rows_n));
	fp_panel_host fp_panel_host_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
		.i_load_start(load_start), .i_load_data(load_data),
		.i_read_start(read_start), .link(lnk), .o_busy(busy),
		.o_key_valid(key_valid), .o_key_map(key_map));
	fp_panel_chk #(.DEBOUNCE_LEN(DEB)) fp_panel_chk_inst (
		.i_sys_clk(i_sys_clk), .i_srst(i_srst),
		.scan_update_select(lnk.scan_update_select),
		.key_read_scan_select(lnk.key_read_scan_select),
		.key_interrupt(lnk.key_interrupt),
		.column_data_buffer(lnk.column_data_buffer),
		.i_key_columns(i_key_columns), .i_gate_active(i_gate_active),
		.o_digit_drive(o_digit_drive), .o_segment_drive(o_segment_drive),
		.o_gate_lamp(o_gate_lamp), .o_key_rows_n(o_key_rows_n));

	// ******
	// Tasks
	// ******
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %0h, want %0h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One host request; waits are bounded so a stuck host cannot hang us.
	task automatic host_op(input logic rd);
		@(posedge i_sys_clk);
		read_start <= rd;
		load_start <= !rd;
		@(posedge i_sys_clk);
		read_start <= 1'b0;
		load_start <= 1'b0;
		repeat (2) @(negedge i_sys_clk);
		for (int i = 0; i < 500 && busy !== 1'b0; i++)
			@(negedge i_sys_clk);
		check(busy, 1'b0);
	endtask

	task automatic wait_irq(input logic lvl);
		for (int i = 0; i < 300 && lnk.key_interrupt !== lvl; i++)
			@(negedge i_sys_clk);
		check(lnk.key_interrupt, lvl);
	endtask

	// ******
	// Monitors
	// ******
	// Random gate activity keeps the lamp logic busy all run long.
	always @(posedge i_sys_clk)
		i_gate_active <= !i_srst && ($urandom_range(0, 3) == 0);

	// Outputs are read at the falling edge, once the registers have settled.
	always @(negedge i_sys_clk)
	begin
		if (disp_on && o_digit_drive !== 16'h0000)
		begin
			lit++;
			seen_slots |= o_digit_drive;
			check(o_segment_drive, load_data[$clog2(o_digit_drive)]);
		end
		if (key_valid === 1'b1)
			check({4'h0, key_map}, key_q.size() ?
				{4'h0, key_q.pop_front()} : 32'hdeadbeef);
	end

	initial
	begin
		#(20000 * 10);
		err_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ******
	// Main sequence
	// ******
	initial
	begin
		void'($urandom(32'hd16e));
		foreach (load_data[i])
			load_data[i] = 8'($urandom());
		repeat (7) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(o_key_rows_n, ROW_FIRST);
		check(lnk.column_data_buffer, COL_IDLE);
		check(lnk.scan_update_select, 1'b1);
		check(lnk.key_interrupt, 1'b0);
		@(posedge i_sys_clk);
		i_srst <= 1'b0;
		$display("Test reset done");
		host_op(1'b0);
		repeat (STEP) @(posedge i_sys_clk);
		disp_on <= 1'b1;
		repeat (30 * STEP) @(posedge i_sys_clk);
		check(seen_slots, 16'h7fff);
		$display("Test display load done");
		// Each slot lasts STEP cycles, of which k are blanked.
		for (int k = 0; k < 3; k++)
		begin
			@(posedge i_sys_clk);
			intensity <= 16'(k);
			repeat (12) @(posedge i_sys_clk);
			lit = 0;
			repeat (15 * STEP) @(posedge i_sys_clk);
			check(lit, 15 * (STEP - k));
		end
		$display("Test intensity done");
		// The last press is the lone extra key in the seventh column.
		for (int t = 0; t < 5; t++)
		begin
			@(posedge i_sys_clk);
			key_r <= (t == 4) ? 2'h3 : 2'($urandom_range(0, 3));
			key_c <= (t == 4) ? 3'h6 : 3'($urandom_range(0, 5));
			key_on <= 1'b1;
			wait_irq(1'b1);
			key_q.push_back(28'h1 << (key_r * 7 + key_c));
			host_op(1'b1);
			@(posedge i_sys_clk);
			key_on <= 1'b0;
			wait_irq(1'b0);
		end
		key_q.push_back(28'h0);
		host_op(1'b1);
		repeat (4) @(negedge i_sys_clk);
		check(key_q.size(), 0);
		$display("Test keyboard done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire

// ===== src/fp_divider.sv
`timescale 1ns/10ps
`default_nettype none
module fp_divider
	import fp_scan_pkg::*;
#(
	parameter int DIV = 100
)(
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_srst,
	// Control
	input  wire logic i_run,
	output logic      o_tick
);
	logic [DIV_W-1:0] count;
	wire              at_end = (count == DIV_W'(DIV - 1));

	// Counting pauses while not running, so a halted scan resumes in phase.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			count  <= '0;
			o_tick <= 1'b0;
		end
		else
		begin
			o_tick <= i_run & at_end;
			if (i_run)
				count <= at_end ? '0 : count + 1'b1;
		end
	end
endmodule // fp_divider
`default_nettype wire

// ===== src/fp_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fp_link_if;
	import fp_scan_pkg::*;
	logic            scan_update_select;
	logic            host_step_clock;
	logic            counter_clear_load;
	logic            key_read_scan_select;
	logic [SEG_W-1:0] host_seg_data;
	logic            key_interrupt;
	logic [COLS-1:0] column_data_buffer;

	modport device (
		input  scan_update_select, host_step_clock, counter_clear_load,
		input  key_read_scan_select, host_seg_data,
		output key_interrupt, column_data_buffer
	);
	modport host (
		output scan_update_select, host_step_clock, counter_clear_load,
		output key_read_scan_select, host_seg_data,
		input  key_interrupt, column_data_buffer
	);
endinterface
`default_nettype wire

// ===== src/fp_panel_device.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R01 - Segment lit only when digit and segment on.
// R02 - Display is in self-scan or update mode.
// R03 - Scan tick advances counter, selects one digit.
// R04 - Counter decoded four-to-sixteen one-hot.
// R05 - Enabled digit shows its memory segment bits.
// R06 - Blank interval after each scan tick.
// R07 - Gate lamp lit for whole gate time.
// R08 - Host drives update select low.
// R09 - Update mode steps counter on host clock.
// R10 - Host clears counter with clear and pulse.
// R11 - Keyboard is in self-scan or read mode.
// R12 - Rows driven low one at a time.
// R13 - Low column asserts detect, halts scan.
// R14 - Debounced key raises host interrupt.
// R15 - Read mode enables buffer, host clocks rows.
// R16 - Host steps exactly one full row scan.
// R17 - Matrix four rows by seven columns, pulled high.
// R18 - Annunciator groups scanned as extra digits.
// R19 - Single low row bit circulates and wraps.
// R20 - Debounce counts continuous detect cycles.
module fp_panel_device
	import fp_scan_pkg::*;
#(
	parameter int SCAN_DIVIDE  = SCAN_DIV,
	parameter int KEY_DIVIDE   = KEY_DIV,
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYC
)(
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_srst,
	// Host link
	fp_link_if.device              link,
	// Panel controls
	input  wire logic [DIV_W-1:0]  i_intensity_adjust,
	input  wire logic              i_gate_active,
	input  wire logic [COLS-1:0]   i_key_columns,
	// Panel drives
	output logic [DEC_W-1:0]       o_digit_drive,
	output logic [SEG_W-1:0]       o_segment_drive,
	output logic                   o_gate_lamp,
	output logic [ROWS-1:0]        o_key_rows_n
);
	// ********************************************************************
	// Storage and state
	// ********************************************************************
	logic [SEG_W-1:0] seg_mem [NUM_SLOTS];
	logic [CNT_W-1:0] digit_counter;
	logic [DIV_W-1:0] blank_count;
	logic             step_d;
	logic             key_step_d;
	logic             read_d;
	logic [ROWS-1:0]  row_shift_register;
	logic [DIV_W-1:0] debounce_count;
	logic             key_irq;
	logic [COLS-1:0]  col_hold;
	logic             scan_tick;
	logic             key_tick;

	// ********************************************************************
	// Decode
	// ********************************************************************
	// Update mode is entered by the host pulling its select low.
	wire update_mode   = ~link.scan_update_select;            // [R02] [R08]
	wire step_rise     = link.host_step_clock & ~step_d;
	wire key_step_rise = link.host_step_clock & ~key_step_d;
	wire read_mode     = link.key_read_scan_select;           // [R11] [R15]
	// Any column pulled low while its row is grounded is a detect.
	wire key_detect    = (i_key_columns != COL_IDLE);         // [R13] [R17]
	wire disp_advance  = update_mode ? step_rise : scan_tick; // [R03] [R09]
	wire counter_wrap  = (digit_counter == CNT_LAST);
	wire [CNT_W-1:0] counter_next = counter_wrap ? CNT_ZERO
		: digit_counter + 1'b1;
	wire blanked       = (blank_count != '0);
	wire slot_valid    = (digit_counter < CNT_W'(NUM_SLOTS));
	wire [ROWS-1:0] next_rows = {row_shift_register[ROWS-2:0],
		row_shift_register[ROWS-1]};                          // [R19]
	wire row_advance   = read_mode ? key_step_rise : key_tick;
	wire read_enter    = read_mode & ~read_d;
	wire debounced     = (debounce_count == DIV_W'(DEBOUNCE_LEN));

	// Scan clocks; the key scan halts while a key is detected.
	fp_divider #(.DIV(SCAN_DIVIDE)) u_scan_div (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_run     (~update_mode),
		.o_tick    (scan_tick)
	);
	fp_divider #(.DIV(KEY_DIVIDE)) u_key_div (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_run     (~read_mode & ~key_detect),                 // [R13]
		.o_tick    (key_tick)
	);

	// ********************************************************************
	// Display counter and memory
	// ********************************************************************
	// The counter clears on a host step while clear is high.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			digit_counter <= CNT_ZERO;
			step_d        <= 1'b0;
		end
		else
		begin
			step_d <= link.host_step_clock;
			if (update_mode && step_rise && link.counter_clear_load)
				digit_counter <= CNT_ZERO;                      // [R10]
			else if (disp_advance)
				digit_counter <= counter_next;                  // [R03] [R09]
		end
	end

	// Host loads the slot addressed by the counter, then steps on.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
				seg_mem[i] <= '0;
		end
		else if (update_mode && step_rise && !link.counter_clear_load
			&& slot_valid)
			seg_mem[digit_counter] <= link.host_seg_data;
	end

	// ********************************************************************
	// Drives and blanking
	// ********************************************************************
	// Blanking trades brightness for duty; a long adjust dims the panel.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			blank_count <= '0;
		else if (disp_advance)
			blank_count <= i_intensity_adjust;                  // [R06]
		else if (blanked)
			blank_count <= blank_count - 1'b1;
	end

	// Digit and segment are both gated, so nothing lights while blanked, in update mode or past the last slot.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			o_digit_drive   <= '0;
			o_segment_drive <= '0;
			o_gate_lamp     <= 1'b0;
		end
		else
		begin
			o_gate_lamp <= i_gate_active;                       // [R07]
			if (update_mode || blanked || !slot_valid)
			begin
				o_digit_drive   <= '0;                          // [R01] [R06]
				o_segment_drive <= '0;
			end
			else
			begin
				o_digit_drive   <= digit_onehot(digit_counter); // [R04] [R18]
				o_segment_drive <= seg_mem[digit_counter];      // [R05] [R01]
			end
		end
	end

	// ********************************************************************
	// Keyboard
	// ********************************************************************
	// One grounded row circulates; detect freezes it via the divider.
	// A read restarts at the first row, else the host could not tell
	// which row its step count stands on after a halted scan.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			row_shift_register <= ROW_FIRST;
			key_step_d         <= 1'b0;
			read_d             <= 1'b0;
		end
		else
		begin
			key_step_d <= link.host_step_clock;
			read_d     <= read_mode;
			if (read_enter)
				row_shift_register <= ROW_FIRST;                // [R15]
			else if (row_advance)
				row_shift_register <= next_rows;                // [R12] [R15]
		end
	end

	// Debounce needs an unbroken detect; any release restarts it.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			debounce_count <= '0;
			key_irq        <= 1'b0;
			col_hold       <= COL_IDLE;
		end
		else
		begin
			if (!key_detect)
				debounce_count <= '0;                           // [R20]
			else if (!debounced)
				debounce_count <= debounce_count + 1'b1;
			key_irq  <= key_detect & debounced;                 // [R14]
			col_hold <= read_mode ? i_key_columns : COL_IDLE;   // [R15]
		end
	end

	// Outputs and link answers come straight from their registers.
	assign o_key_rows_n            = row_shift_register;
	assign link.key_interrupt      = key_irq;
	assign link.column_data_buffer = col_hold;
endmodule // fp_panel_device
`default_nettype wire

// ===== src/fp_panel_host.sv
`timescale 1ns/10ps
`default_nettype none
module fp_panel_host
	import fp_scan_pkg::*;
#(
	parameter int HALF = 4
)(
	// Clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_srst,
	// Display load request
	input  wire logic                i_load_start,
	input  wire logic [SEG_W-1:0]    i_load_data [NUM_SLOTS],
	// Key read request
	input  wire logic                i_read_start,
	// Link
	fp_link_if.host                  link,
	// Status
	output logic                     o_busy,
	output logic                     o_key_valid,
	output logic [ROWS*COLS-1:0]     o_key_map
);
	typedef enum logic [2:0] {IDLE, CLR, LOAD, READ, DONE} state_e;
	state_e           state;
	logic [7:0]       phase;
	logic [CNT_W-1:0] slot;
	logic [1:0]       row;
	logic             sel_n, step, clr, rd;
	logic [SEG_W-1:0] data;

	// A step spans 2*HALF cycles; these mark the end of each half.
	wire half_done = (phase == 8'(HALF - 1));
	wire full_done = (phase == 8'(2*HALF - 1));

	// Each step is a low half then a high half; the device sees the rise.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			state       <= IDLE;
			phase       <= '0;
			slot        <= '0;
			row         <= '0;
			sel_n       <= 1'b0;
			step        <= 1'b0;
			clr         <= 1'b0;
			rd          <= 1'b0;
			data        <= '0;
			o_busy      <= 1'b0;
			o_key_valid <= 1'b0;
			o_key_map   <= '0;
		end
		else
		begin
			phase <= (state == IDLE || full_done) ? '0 : phase + 1'b1;
			o_key_valid <= 1'b0;
			step <= (state != IDLE) && (state != DONE) && half_done ? 1'b1
				: (full_done ? 1'b0 : step);            // [R09]
			case (state)
				IDLE:
				begin
					if (i_load_start)
					begin
						state  <= CLR;
						sel_n  <= 1'b1;                 // [R08]
						clr    <= 1'b1;                 // [R10]
						o_busy <= 1'b1;
					end
					else if (i_read_start)
					begin
						state  <= READ;
						rd     <= 1'b1;                 // [R15]
						row    <= '0;
						o_busy <= 1'b1;
					end
				end
				CLR:
				begin
					if (full_done)
					begin
						clr   <= 1'b0;
						slot  <= '0;
						data  <= i_load_data[0];
						state <= LOAD;
					end
				end
				LOAD:
				begin
					if (full_done)
					begin
						slot <= slot + 1'b1;
						data <= i_load_data[(slot + 1'b1) % NUM_SLOTS];
						if (slot == CNT_W'(NUM_SLOTS - 1))
							state <= DONE;
					end
				end
				READ:
				begin
					if (half_done)
					begin
						o_key_map[row*COLS +: COLS] <= ~link.column_data_buffer;
						row <= row + 1'b1;
						if (row == 2'(ROWS - 1))
							state <= DONE;              // [R16]
					end
				end
				DONE:
				begin
					sel_n       <= 1'b0;
					rd          <= 1'b0;
					step        <= 1'b0;
					o_busy      <= 1'b0;
					o_key_valid <= rd;
					state       <= IDLE;
				end
				default:
					state <= IDLE;
			endcase
		end
	end

	// Link drives; select is low while the host owns the display.
	assign link.scan_update_select   = ~sel_n;
	assign link.host_step_clock      = step;
	assign link.counter_clear_load   = clr;
	assign link.key_read_scan_select = rd;
	assign link.host_seg_data        = data;
endmodule // fp_panel_host
`default_nettype wire

// ===== src/fp_scan_pkg.sv
`default_nettype none
package fp_scan_pkg;

	// ********************************************************************
	// Display geometry
	// ********************************************************************
	localparam int NUM_DIGITS       = 12;
	localparam int NUM_ANNUN        = 3;
	localparam int NUM_SLOTS        = NUM_DIGITS + NUM_ANNUN;
	localparam int SEG_W            = 8;
	localparam int CNT_W            = 4;
	localparam int DEC_W            = 16;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'he;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

	// ********************************************************************
	// Keyboard geometry
	// ********************************************************************
	localparam int ROWS             = 4;
	localparam int COLS             = 7;
	localparam logic [ROWS-1:0] ROW_FIRST = 4'he;
	localparam logic [ROWS-1:0] ROW_IDLE  = 4'hf;
	localparam logic [COLS-1:0] COL_IDLE  = 7'h7f;

	// ********************************************************************
	// Timing at 100 MHz
	// ********************************************************************
	localparam int CLK_NS           = 10;
	localparam int SCAN_PERIOD_NS   = 1000;
	localparam int SCAN_DIV         = SCAN_PERIOD_NS / CLK_NS;
	localparam int KEY_PERIOD_NS    = 2000;
	localparam int KEY_DIV          = KEY_PERIOD_NS / CLK_NS;
	localparam int DEBOUNCE_NS      = 5000;
	localparam int DEBOUNCE_CYC     = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_W            = 16;

	// One-hot digit decode; slot number in, digit driver select out.
	function automatic logic [DEC_W-1:0] digit_onehot(
		input logic [CNT_W-1:0] idx
	);
		digit_onehot = {{(DEC_W-1){1'b0}}, 1'b1} << idx;
	endfunction

endpackage
`default_nettype wire
